// *** core/ov_pkg.sv ***
// Purpose: constants and types of the overvoltage stages
// Assumes: 50 MHz clock, fundamental magnitudes in volts
// Notes: pick-up and dead band held in per mille, elapsed delay in percent
package ov_pkg;

  localparam int CLOCK_HZ = 50_000_000;
  localparam int MS_PER_SECOND = 1000;
  localparam int MS_TICK_CYCLES = CLOCK_HZ / MS_PER_SECOND;
  localparam int FORCE_TIMEOUT_MIN = 5;
  localparam int FORCE_TIMEOUT_MS = FORCE_TIMEOUT_MIN * 60 * MS_PER_SECOND;

  localparam int STAGES = 3;
  localparam int BANKS = 4;
  localparam int RECORDS = 8;
  localparam int SOURCE_BITS = 16;

  localparam logic [15:0] PMIL_FULL = 16'h03e8;
  localparam logic [7:0] PCT_FULL = 8'h64;
  localparam logic [15:0] COUNT_MAX = 16'hffff;

  localparam logic [15:0] PICKUP_RESET = 16'h044c;
  localparam logic [15:0] OPERATE_RESET = 16'h03e8;
  localparam logic [15:0] DEADBAND_RESET = 16'h001e;
  localparam logic [15:0] HOLD_RESET = 16'h0000;
  localparam logic [1:0] MANUAL_BANK_RESET = 2'h0;
  localparam logic [3:0] SOURCE_INDEX_RESET = 4'h0;
  localparam logic [1:0] BANK_WHEN_HIGH = 2'h1;
  localparam logic [1:0] BANK_WHEN_LOW = 2'h0;

  typedef enum logic [2:0] {
    FIELD_PICKUP,
    FIELD_OPERATE,
    FIELD_DEADBAND,
    FIELD_RELEASE_HOLD,
    FIELD_MANUAL_BANK,
    FIELD_SOURCE_KIND,
    FIELD_SOURCE_INDEX
  } setting_field_t;

  typedef enum logic [2:0] {
    SOURCE_NONE,
    SOURCE_DIGITAL,
    SOURCE_VIRTUAL_IN,
    SOURCE_INDICATOR,
    SOURCE_VIRTUAL_OUT,
    SOURCE_FUNCTION_KEY
  } bank_source_t;

  typedef enum logic [1:0] {
    STATUS_IDLE,
    STATUS_BLOCKED,
    STATUS_STARTED,
    STATUS_TRIPPED
  } stage_status_t;

  typedef struct packed {
    logic [15:0] pickup_pmil;
    logic [15:0] operate_ms;
    logic [15:0] deadband_pmil;
    logic [15:0] release_hold_time;
  } stage_setting_t;

  typedef struct packed {
    logic [31:0] date;
    logic [31:0] ms_of_day;
  } time_stamp_t;

  typedef struct packed {
    logic valid;
    time_stamp_t stamp;
    logic [15:0] fault_pmil;
    logic [7:0] elapsed_delay_pct;
    logic [1:0] bank;
  } fault_record_t;

endpackage

// *** core/ov_stage.sv ***
// Purpose: one definite-time overvoltage detector
// Assumes: ms_tick pulses once per ms; thresholds in volts
// Notes: elapsed time saturates rather than wrapping
`timescale 1ns/100ps
`default_nettype none
module ov_stage
  import ov_pkg::*;
#(
  parameter bit HAS_RELEASE_HOLD = 1'b0
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ms_tick,
  input wire logic blocked,
  input wire logic [15:0] umax,
  input wire logic [31:0] pickup_volts,
  input wire logic [31:0] release_volts,
  input wire logic [15:0] operate_ms,
  input wire logic [15:0] release_hold_time,
  output logic picked,
  output logic tripped,
  output logic [15:0] elapsed_ms
);

  logic [15:0] hold_ms;
  logic [31:0] umax_wide;

  assign umax_wide = {16'h0000, umax};

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      picked <= 1'b0;
    end else if (blocked) begin
      picked <= 1'b0;
    end else if (!picked && umax_wide > pickup_volts) begin
      picked <= 1'b1;
    end else if (picked && umax_wide < release_volts) begin
      picked <= 1'b0;
    end
  end

  // hold keeps intermittent fault time
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      elapsed_ms <= 16'h0000;
    end else if (blocked) begin
      elapsed_ms <= 16'h0000;
    end else if (picked) begin
      if (ms_tick && elapsed_ms != COUNT_MAX) begin
        elapsed_ms <= elapsed_ms + 16'h0001;
      end
    end else if (!HAS_RELEASE_HOLD || hold_ms >= release_hold_time) begin
      elapsed_ms <= 16'h0000;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hold_ms <= 16'h0000;
    end else if (blocked || picked) begin
      hold_ms <= 16'h0000;
    end else if (ms_tick && hold_ms != COUNT_MAX) begin
      hold_ms <= hold_ms + 16'h0001;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tripped <= 1'b0;
    end else begin
      tripped <= !blocked && picked && elapsed_ms >= operate_ms;
    end
  end

endmodule // ov_stage
`default_nettype wire

// *** core/overvoltage_protection_stages.sv ***
// Purpose: three overvoltage stages with banks, counters, force and records
// Assumes: control inputs on this clock; digital inputs and keys are async pins
// Notes: writes need auth_granted with the strobe
`timescale 1ns/100ps
`default_nettype none
// Operation
// - only fundamental line-to-line magnitudes, any measuring mode.
// - supervise the largest line-to-line magnitude, in volts.
// - start when a line-to-line voltage exceeds pick-up.
// - trip when pick-up lasts beyond the operate time.
// - three stages, own pick-up and definite operate time.
// - stage one clears its timer only after the release hold.
// - stage one refault resumes the kept time.
// - release below pick-up less dead band, default 3 %.
// - four setting banks per stage, by manual choice; a signal picks bank 0 or 1.
// - selector picks the bank switching source, or none.
// - start and trip counts per stage, clearable.
// - shared force flag, cleared after five minutes.
// - start and trip follow test inputs only under force.
// - status is idle, blocked, started or tripped.
// - settings and force change only when authorised.
// - eight latest faults: stamp, peak voltage, elapsed delay, bank.
// - elapsed delay as percent of operate time, 100 means trip.
// - pick-up in percent of nominal, also shown in volts; held in per mille.
module overvoltage_protection_stages
  import ov_pkg::*;
#(
  parameter int TICK_CYCLES = MS_TICK_CYCLES,
  parameter int FORCE_MS = FORCE_TIMEOUT_MS
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [15:0] u12_fund,
  input wire logic [15:0] u23_fund,
  input wire logic [15:0] u31_fund,
  input wire logic [15:0] nominal_volts,
  input wire time_stamp_t time_stamp,
  input wire logic [2:0] stage_block,
  input wire logic auth_granted,
  input wire logic setting_write,
  input wire logic [1:0] setting_stage,
  input wire logic [1:0] setting_bank,
  input wire setting_field_t setting_field,
  input wire logic [15:0] setting_data,
  input wire logic force_write,
  input wire logic force_value,
  input wire logic [2:0] forced_start,
  input wire logic [2:0] forced_trip,
  input wire logic [SOURCE_BITS-1:0] digital_input_n,
  input wire logic [SOURCE_BITS-1:0] virtual_input_n,
  input wire logic [SOURCE_BITS-1:0] indicator_signal_n,
  input wire logic [SOURCE_BITS-1:0] virtual_output_n,
  input wire logic [SOURCE_BITS-1:0] function_key_n,
  input wire logic [2:0] start_count_clear,
  input wire logic [2:0] trip_count_clear,
  input wire logic [1:0] record_stage,
  input wire logic [2:0] record_index,
  output logic [15:0] umax_volts,
  output logic [2:0] stage_start,
  output logic [2:0] stage_trip,
  output stage_status_t [2:0] stage_status,
  output logic [2:0][15:0] start_event_count,
  output logic [2:0][15:0] trip_event_count,
  output logic [2:0][31:0] pickup_primary_volts,
  output logic [1:0] active_settings_bank,
  output bank_source_t bank_select_source,
  output logic force_active,
  output fault_record_t record_data
);

  function automatic logic [15:0] max3(input logic [15:0] a, input logic [15:0] b,
                                       input logic [15:0] c);
    logic [15:0] m;
    m = (a > b) ? a : b;
    return (m > c) ? m : c;
  endfunction

  function automatic logic [31:0] scale_pmil(input logic [31:0] base, input logic [15:0] pmil);
    logic [47:0] product;
    product = 48'(base) * 48'(pmil);
    return 32'(product / 48'(PMIL_FULL));
  endfunction

  function automatic logic [7:0] pct_of(input logic [15:0] part, input logic [15:0] whole);
    logic [31:0] ratio;
    ratio = 32'h0000_0000;
    if (whole == 16'h0000 || part >= whole) begin
      return PCT_FULL;
    end
    ratio = (32'(part) * 32'(PCT_FULL)) / 32'(whole);
    return ratio[7:0];
  endfunction

  logic ms_tick;
  logic [31:0] tick_count;
  logic [31:0] force_ms_count;
  logic [SOURCE_BITS-1:0] digital_meta;
  logic [SOURCE_BITS-1:0] digital_sync;
  logic [SOURCE_BITS-1:0] fkey_meta;
  logic [SOURCE_BITS-1:0] fkey_sync;
  logic [1:0] manual_bank;
  logic [3:0] source_index;
  logic bank_signal;
  logic settings_write_ok;
  stage_setting_t settings [STAGES][BANKS];
  logic [2:0] picked;
  logic [2:0] tripped;
  logic [2:0] next_start;
  logic [2:0] next_trip;
  logic [15:0] elapsed [STAGES];
  fault_record_t records [STAGES][RECORDS];

  assign settings_write_ok = setting_write && auth_granted;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tick_count <= 32'h0000_0000;
      ms_tick <= 1'b0;
    end else if (tick_count >= 32'(TICK_CYCLES - 1)) begin
      tick_count <= 32'h0000_0000;
      ms_tick <= 1'b1;
    end else begin
      tick_count <= tick_count + 32'h0000_0001;
      ms_tick <= 1'b0;
    end
  end

  // inputs are fundamentals already, so mode-independent
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      umax_volts <= 16'h0000;
    end else begin
      umax_volts <= max3(u12_fund, u23_fund, u31_fund);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      digital_meta <= '0;
      digital_sync <= '0;
      fkey_meta <= '0;
      fkey_sync <= '0;
    end else begin
      digital_meta <= digital_input_n;
      digital_sync <= digital_meta;
      fkey_meta <= function_key_n;
      fkey_sync <= fkey_meta;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      manual_bank <= MANUAL_BANK_RESET;
      bank_select_source <= SOURCE_NONE;
      source_index <= SOURCE_INDEX_RESET;
    end else if (settings_write_ok) begin
      if (setting_field == FIELD_MANUAL_BANK) begin
        manual_bank <= setting_data[1:0];
      end
      if (setting_field == FIELD_SOURCE_KIND && setting_data[2:0] <= 3'(SOURCE_FUNCTION_KEY)) begin
        bank_select_source <= bank_source_t'(setting_data[2:0]);
      end
      if (setting_field == FIELD_SOURCE_INDEX) begin
        source_index <= setting_data[3:0];
      end
    end
  end

  always_comb begin
    bank_signal = 1'b0;
    unique case (bank_select_source)
      SOURCE_NONE: bank_signal = 1'b0;
      SOURCE_DIGITAL: bank_signal = digital_sync[source_index];
      SOURCE_VIRTUAL_IN: bank_signal = virtual_input_n[source_index];
      SOURCE_INDICATOR: bank_signal = indicator_signal_n[source_index];
      SOURCE_VIRTUAL_OUT: bank_signal = virtual_output_n[source_index];
      SOURCE_FUNCTION_KEY: bank_signal = fkey_sync[source_index];
      default: bank_signal = 1'b0;
    endcase
  end

  // source none: manual bank; else the signal picks bank 1 or 0
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      active_settings_bank <= MANUAL_BANK_RESET;
    end else if (bank_select_source == SOURCE_NONE) begin
      active_settings_bank <= manual_bank;
    end else begin
      active_settings_bank <= bank_signal ? BANK_WHEN_HIGH : BANK_WHEN_LOW;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int s = 0; s < STAGES; s++) begin
        for (int b = 0; b < BANKS; b++) begin
          settings[s][b] <= '{PICKUP_RESET, OPERATE_RESET, DEADBAND_RESET, HOLD_RESET};
        end
      end
    end else if (settings_write_ok && setting_stage < 2'(STAGES)) begin
      case (setting_field)
        FIELD_PICKUP: settings[setting_stage][setting_bank].pickup_pmil <= setting_data;
        FIELD_OPERATE: settings[setting_stage][setting_bank].operate_ms <= setting_data;
        FIELD_DEADBAND: settings[setting_stage][setting_bank].deadband_pmil <= setting_data;
        FIELD_RELEASE_HOLD:
          settings[setting_stage][setting_bank].release_hold_time <= setting_data;
        default: ;
      endcase
    end
  end

  // an authorised write wins over a same-cycle expiry
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      force_active <= 1'b0;
      force_ms_count <= 32'h0000_0000;
    end else if (force_write && auth_granted) begin
      force_active <= force_value;
      force_ms_count <= 32'h0000_0000;
    end else if (force_active && ms_tick) begin
      if (force_ms_count >= 32'(FORCE_MS - 1)) begin
        force_active <= 1'b0;
        force_ms_count <= 32'h0000_0000;
      end else begin
        force_ms_count <= force_ms_count + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      record_data <= '0;
    end else if (record_stage < 2'(STAGES)) begin
      record_data <= records[record_stage][record_index];
    end else begin
      record_data <= '0;
    end
  end

  for (genvar g = 0; g < STAGES; g++) begin : g_stage
    stage_setting_t active;
    logic [31:0] pickup_calc;
    logic [31:0] release_calc;
    logic [15:0] keep_pmil;
    logic start_rise;
    logic start_fall;
    logic trip_rise;
    logic [2:0] write_ptr;
    logic [15:0] fault_peak;
    logic [15:0] fault_elapsed;
    logic fault_tripped;
    logic [1:0] fault_bank;
    time_stamp_t fault_stamp;

    assign active = settings[g][active_settings_bank];

    always_comb begin
      keep_pmil = (active.deadband_pmil > PMIL_FULL) ? 16'h0000 : PMIL_FULL - active.deadband_pmil;
      pickup_calc = scale_pmil({16'h0000, nominal_volts}, active.pickup_pmil);
      release_calc = scale_pmil(pickup_calc, keep_pmil);
    end

    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        pickup_primary_volts[g] <= 32'h0000_0000;
      end else begin
        pickup_primary_volts[g] <= pickup_calc;
      end
    end

    ov_stage #(
      .HAS_RELEASE_HOLD(g == 0)
    ) u_stage (
      .clock(clock),
      .rst_n(rst_n),
      .ms_tick(ms_tick),
      .blocked(stage_block[g]),
      .umax(umax_volts),
      .pickup_volts(pickup_calc),
      .release_volts(release_calc),
      .operate_ms(active.operate_ms),
      .release_hold_time(active.release_hold_time),
      .picked(picked[g]),
      .tripped(tripped[g]),
      .elapsed_ms(elapsed[g])
    );

    assign next_start[g] = force_active ? forced_start[g] : picked[g];
    assign next_trip[g] = force_active ? forced_trip[g] : tripped[g];
    assign start_rise = next_start[g] && !stage_start[g];
    assign start_fall = !next_start[g] && stage_start[g];
    assign trip_rise = next_trip[g] && !stage_trip[g];

    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        stage_start[g] <= 1'b0;
        stage_trip[g] <= 1'b0;
        stage_status[g] <= STATUS_IDLE;
      end else begin
        stage_start[g] <= next_start[g];
        stage_trip[g] <= next_trip[g];
        if (stage_block[g]) begin
          stage_status[g] <= STATUS_BLOCKED;
        end else if (next_trip[g]) begin
          stage_status[g] <= STATUS_TRIPPED;
        end else if (next_start[g]) begin
          stage_status[g] <= STATUS_STARTED;
        end else begin
          stage_status[g] <= STATUS_IDLE;
        end
      end
    end

    // set beats clear
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        start_event_count[g] <= 16'h0000;
        trip_event_count[g] <= 16'h0000;
      end else begin
        if (start_rise) begin
          start_event_count[g] <= start_count_clear[g] ? 16'h0001 : start_event_count[g] + 16'h0001;
        end else if (start_count_clear[g]) begin
          start_event_count[g] <= 16'h0000;
        end
        if (trip_rise) begin
          trip_event_count[g] <= trip_count_clear[g] ? 16'h0001 : trip_event_count[g] + 16'h0001;
        end else if (trip_count_clear[g]) begin
          trip_event_count[g] <= 16'h0000;
        end
      end
    end

    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        fault_peak <= 16'h0000;
        fault_elapsed <= 16'h0000;
        fault_tripped <= 1'b0;
        fault_bank <= 2'h0;
        fault_stamp <= '0;
      end else if (start_rise) begin
        fault_peak <= umax_volts;
        fault_elapsed <= elapsed[g];
        fault_tripped <= next_trip[g];
        fault_bank <= active_settings_bank;
        fault_stamp <= time_stamp;
      end else if (stage_start[g]) begin
        if (umax_volts > fault_peak) begin
          fault_peak <= umax_volts;
        end
        if (elapsed[g] > fault_elapsed) begin
          fault_elapsed <= elapsed[g];
        end
        fault_tripped <= fault_tripped || next_trip[g];
      end
    end

    // ring overwrites the oldest of eight
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        write_ptr <= 3'h0;
        for (int r = 0; r < RECORDS; r++) begin
          records[g][r] <= '0;
        end
      end else if (start_fall) begin
        records[g][write_ptr].valid <= 1'b1;
        records[g][write_ptr].stamp <= fault_stamp;
        records[g][write_ptr].fault_pmil <= (nominal_volts == 16'h0000) ? COUNT_MAX :
          16'((32'(fault_peak) * 32'(PMIL_FULL)) / 32'(nominal_volts));
        records[g][write_ptr].elapsed_delay_pct <= fault_tripped ? PCT_FULL :
          pct_of(fault_elapsed, active.operate_ms);
        records[g][write_ptr].bank <= fault_bank;
        write_ptr <= write_ptr + 3'h1;
      end
    end
  end

endmodule // overvoltage_protection_stages
`default_nettype wire

// *** tb/ov_front_end.sv ***
// Purpose: voltage front end model
// Assumes: only fundamentals are presented
// Notes: the selected phase carries the level, the others half of it
`timescale 1ns/100ps
`default_nettype none
module ov_front_end (
  input wire logic [15:0] level,
  input wire logic [1:0] phase,
  output logic [15:0] u12_fund,
  output logic [15:0] u23_fund,
  output logic [15:0] u31_fund
);
  // unequal phases expose a wrong maximum
  assign u12_fund = (phase == 2'h0) ? level : level >> 1;
  assign u23_fund = (phase == 2'h1) ? level : level >> 1;
  assign u31_fund = (phase == 2'h2) ? level : level >> 1;
endmodule // ov_front_end
`default_nettype wire

// *** tb/ov_checker.sv ***
// Purpose: concurrent checks on the overvoltage stage ports
// Assumes: single clock domain, async active-low reset
// Notes: bound at the file's foot
`timescale 1ns/100ps
`default_nettype none
module ov_checker
  import ov_pkg::*;
#(
  parameter int TICK_CYCLES = MS_TICK_CYCLES,
  parameter int FORCE_MS = FORCE_TIMEOUT_MS
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [15:0] u12_fund,
  input wire logic [15:0] u23_fund,
  input wire logic [15:0] u31_fund,
  input wire logic [15:0] umax_volts,
  input wire logic [2:0] stage_start,
  input wire logic [2:0] stage_trip,
  input wire logic [2:0][31:0] pickup_primary_volts,
  input wire logic force_write,
  input wire logic force_value,
  input wire logic auth_granted,
  input wire logic [2:0] forced_start,
  input wire logic [2:0] forced_trip,
  input wire logic [2:0] stage_block,
  input wire logic force_active,
  input wire logic [2:0][15:0] start_event_count,
  input wire logic [2:0] start_count_clear
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic [15:0] mx;
  logic [31:0] held;
  always_comb begin
    mx = (u12_fund > u23_fund) ? u12_fund : u23_fund;
    mx = (u31_fund > mx) ? u31_fund : mx;
  end
  // tick phase is arbitrary, so one extra millisecond of slack
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) held <= 32'h0;
    else if (!force_active || (force_write && auth_granted)) held <= 32'h0;
    else held <= held + 32'h1;
  end
  umax_max_a: assert property (1 |=> umax_volts == $past(mx))
    else $error("umax not the largest input");
  start_cause_a: assert property ($rose(stage_start[1]) && !force_active && !$past(force_active)
    |-> $past(umax_volts, 2) > $past(pickup_primary_volts[1], 2)) else $error("start without cause");
  force_take_a: assert property (force_write && auth_granted |=> force_active == $past(force_value))
    else $error("force write not taken");
  force_hold_a: assert property (!force_active && !(force_write && auth_granted) |=> !force_active)
    else $error("force set without authorisation");
  force_limit_a: assert property (held <= (FORCE_MS + 1) * TICK_CYCLES + 4)
    else $error("force outlived its timeout");
  forced_follow_a: assert property (force_active && stage_block == 3'h0 |=>
    stage_start == $past(forced_start) && stage_trip == $past(forced_trip)) else $error("forced value lost");
  count_step_a: assert property ($changed(start_event_count[0]) |-> $past(start_count_clear[0])
    || start_event_count[0] == $past(start_event_count[0]) + 16'h1) else $error("count jumped");
  count_clear_a: assert property (start_count_clear[2] |=> start_event_count[2] <= 16'h1)
    else $error("count not cleared");
endmodule // ov_checker
bind overvoltage_protection_stages ov_checker #(.TICK_CYCLES(TICK_CYCLES), .FORCE_MS(FORCE_MS)) i_chk (
  .clock(clock), .rst_n(rst_n), .u12_fund(u12_fund), .u23_fund(u23_fund), .u31_fund(u31_fund),
  .umax_volts(umax_volts), .stage_start(stage_start), .stage_trip(stage_trip),
  .pickup_primary_volts(pickup_primary_volts), .force_write(force_write),
  .force_value(force_value), .auth_granted(auth_granted), .forced_start(forced_start),
  .forced_trip(forced_trip), .stage_block(stage_block), .force_active(force_active),
  .start_event_count(start_event_count), .start_count_clear(start_count_clear));
`default_nettype wire

// *** tb/overvoltage_protection_stages_bench.sv ***
// Purpose: bench for the overvoltage stages
// Assumes: 4 cycles per ms tick, force timeout of 5 ms
// Notes: nominal is fixed at 1000 V, so per mille equals volts
`timescale 1ns/100ps
`default_nettype none
module overvoltage_protection_stages_bench;
  import ov_pkg::*;
  localparam int T = 4;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] level = 16'h0;
  logic [1:0] phase = 2'h0;
  logic [2:0] stage_block = 3'h0;
  logic auth = 1'b0;
  logic wr_en = 1'b0;
  logic [1:0] w_stage = 2'h0;
  logic [1:0] w_bank = 2'h0;
  setting_field_t w_field = FIELD_PICKUP;
  logic [15:0] w_data = 16'h0;
  logic force_write = 1'b0;
  logic [2:0] f_start = 3'h0;
  logic [2:0] f_trip = 3'h0;
  logic [4:0][15:0] src = '0;
  logic [2:0] clr = 3'h0;
  logic [1:0] r_stage = 2'h0;
  logic [31:0] cycles = 32'h0;
  logic [15:0] u12, u23, u31, umax_volts;
  logic [2:0] stage_start, stage_trip;
  stage_status_t [2:0] stage_status;
  logic [2:0][15:0] start_event_count, trip_event_count;
  logic [2:0][31:0] pickup_primary_volts;
  logic [1:0] active_settings_bank;
  bank_source_t bank_select_source;
  logic force_active;
  fault_record_t rec;
  int compares = 0;
  int mismatches = 0;
  int seed = 71;
  int n;
  logic [15:0] pk [3] = '{16'h044c, 16'h04b0, 16'h0514};
  logic [15:0] op [3] = '{16'h0008, 16'h0006, 16'h0004};

  ov_front_end i_fe (.level(level), .phase(phase), .u12_fund(u12), .u23_fund(u23), .u31_fund(u31));
  overvoltage_protection_stages #(.TICK_CYCLES(T), .FORCE_MS(5)) i_dut (
    .clock(clock), .rst_n(rst_n), .u12_fund(u12), .u23_fund(u23), .u31_fund(u31),
    .nominal_volts(16'h03e8), .time_stamp({32'h1, cycles}), .stage_block(stage_block),
    .auth_granted(auth), .setting_write(wr_en), .setting_stage(w_stage), .setting_bank(w_bank),
    .setting_field(w_field), .setting_data(w_data), .force_write(force_write),
    .force_value(1'b1), .forced_start(f_start), .forced_trip(f_trip),
    .digital_input_n(src[0]), .virtual_input_n(src[1]), .indicator_signal_n(src[2]),
    .virtual_output_n(src[3]), .function_key_n(src[4]), .start_count_clear(clr),
    .trip_count_clear(clr), .record_stage(r_stage), .record_index(3'h0),
    .umax_volts(umax_volts), .stage_start(stage_start), .stage_trip(stage_trip),
    .stage_status(stage_status), .start_event_count(start_event_count),
    .trip_event_count(trip_event_count), .pickup_primary_volts(pickup_primary_volts),
    .active_settings_bank(active_settings_bank), .bank_select_source(bank_select_source),
    .force_active(force_active), .record_data(rec));

  always #10 clock = ~clock;
  always @(posedge clock) begin
    cycles <= cycles + 32'h1;
    if (cycles == 32'd20000) begin
      mismatches++;
      results();
    end
  end

  function automatic logic [31:0] pv(input logic [31:0] pm);
    return 32'h3e8 * pm / 32'h3e8;
  endfunction
  function automatic logic [15:0] rel(input logic [31:0] p, input logic [31:0] d);
    return 16'(p * (32'h3e8 - d) / 32'h3e8);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [1:0] s, b, input setting_field_t f, input logic [15:0] d, input a);
    @(posedge clock);
    {wr_en, auth, w_stage, w_bank, w_field, w_data} <= {1'b1, a, s, b, f, d};
    @(posedge clock);
    {wr_en, auth} <= 2'b00;
  endtask
  task automatic lv(input logic [15:0] v, input logic [1:0] p);
    @(posedge clock);
    level <= v;
    phase <= p;
  endtask
  task automatic wst(input int k, input bit trip);
    n = 0;
    while ((trip ? stage_trip[k] : stage_start[k]) !== 1'b1 && n < 400) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic frc(input logic a);
    @(posedge clock);
    {force_write, auth} <= {1'b1, a};
    @(posedge clock);
    {force_write, auth} <= 2'b00;
  endtask
  task automatic results();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    cyc(3);
    chk(pickup_primary_volts[0], pv(PICKUP_RESET));
    chk(bank_select_source, SOURCE_NONE);
    chk(stage_status[0], STATUS_IDLE);
    for (int k = 0; k < 3; k++) begin
      wr(2'(k), 2'h0, FIELD_PICKUP, pk[k], 1'b1);
      wr(2'(k), 2'h0, FIELD_OPERATE, op[k], 1'b1);
    end
    wr(2'h0, 2'h0, FIELD_RELEASE_HOLD, 16'h0014, 1'b1);
    wr(2'h1, 2'h0, FIELD_DEADBAND, 16'h0032, 1'b1);
    wr(2'h1, 2'h0, FIELD_PICKUP, 16'h0100, 1'b0);
    cyc(3);
    chk(pickup_primary_volts[1], pv(pk[1]));
    repeat (40) begin
      lv(16'($unsigned($random(seed)) % 1000), 2'($unsigned($random(seed)) % 3));
      cyc(2);
      chk(umax_volts, level);
    end
    chk(stage_start, 3'h0);
    $display("setup done");
    lv(16'h0546, 2'h1);
    wst(2, 1'b0);
    chk(stage_start, 3'h7);
    wst(2, 1'b1);
    chk(n >= 3 * T - 1 && n <= 4 * T + 3, 1'b1);
    chk(stage_trip[1], 1'b0);
    cyc(2);
    chk(stage_status[2], STATUS_TRIPPED);
    chk({start_event_count[2], trip_event_count[2]}, {16'h1, 16'h1});
    lv(rel(pk[1], 16'h0032), 2'h2);
    cyc(8);
    chk(stage_start, 3'h3);
    lv(rel(pk[1], 16'h0032) - 16'h1, 2'h0);
    cyc(8);
    chk(stage_start, 3'h1);
    r_stage <= 2'h2;
    cyc(3);
    chk({rec.valid, rec.fault_pmil, rec.bank}, {1'b1, 16'h0546, 2'h0});
    chk(rec.elapsed_delay_pct, PCT_FULL);
    $display("trip done");
    lv(16'h0, 2'h0);
    cyc(26 * T);
    clr <= 3'h7;
    cyc(1);
    clr <= 3'h0;
    cyc(2);
    chk({start_event_count[0], trip_event_count[2]}, 32'h0);
    lv(16'h047e, 2'h0);
    wst(0, 1'b0);
    cyc(4 * T);
    lv(16'h0, 2'h0);
    cyc(3 * T);
    lv(16'h047e, 2'h0);
    wst(0, 1'b1);
    chk(n <= 6 * T + 2, 1'b1);
    lv(16'h0, 2'h0);
    cyc(25 * T);
    lv(16'h047e, 2'h0);
    wst(0, 1'b1);
    chk(n >= 7 * T, 1'b1);
    stage_block <= 3'h1;
    cyc(3);
    chk(stage_status[0], STATUS_BLOCKED);
    chk(stage_trip[0], 1'b0);
    lv(16'h0, 2'h0);
    stage_block <= 3'h0;
    $display("hold done");
    f_start <= 3'($random(seed));
    f_trip <= 3'($random(seed));
    frc(1'b0);
    cyc(2);
    chk(force_active, 1'b0);
    frc(1'b1);
    cyc(2);
    chk({stage_start, stage_trip}, {f_start, f_trip});
    cyc(7 * T);
    chk(force_active, 1'b0);
    $display("force done");
    wr(2'h0, 2'h1, FIELD_PICKUP, 16'h03e8, 1'b1);
    for (int s = 1; s < 6; s++) begin
      wr(2'h0, 2'h0, FIELD_SOURCE_KIND, 16'(s), 1'b1);
      wr(2'h0, 2'h0, FIELD_SOURCE_INDEX, 16'h0003, 1'b1);
      src[s - 1] <= 16'h0008;
      cyc(6);
      chk({active_settings_bank, 3'(bank_select_source)}, {BANK_WHEN_HIGH, 3'(s)});
      chk(pickup_primary_volts[0], pv(16'h03e8));
      src <= '0;
      cyc(6);
      chk(active_settings_bank, BANK_WHEN_LOW);
    end
    wr(2'h0, 2'h0, FIELD_SOURCE_KIND, 16'h0, 1'b1);
    wr(2'h0, 2'h0, FIELD_MANUAL_BANK, 16'h2, 1'b1);
    cyc(4);
    chk(active_settings_bank, 2'h2);
    $display("banks done");
    results();
  end
endmodule // overvoltage_protection_stages_bench
`default_nettype wire
